// ==== include/prot_pkg.sv ====
// Constants shared by the flyback mode and protection logic.
package prot_pkg;
   localparam int unsigned CLK_MHZ          = 200;
   localparam int unsigned JITTER_HZ        = 9000;
   localparam longint unsigned CLK_HZ       = 64'd200_000_000;
   localparam int unsigned JITTER_HALF_CYC  =
      int'(CLK_HZ / (2 * JITTER_HZ));
   localparam int unsigned UV_BLANK_MS      = 20;
   localparam int unsigned UV_BLANK_CYC     = UV_BLANK_MS * 1000 * CLK_MHZ;
   localparam int unsigned FAULT_CYCLES     = 4;
   localparam int unsigned JITTER_PCT       = 5;
   localparam int unsigned LEVEL_W          = 12;
   localparam int unsigned STARTUP_PULSE_CYC = 200;
   typedef enum logic [2:0] {
      ST_CHARGE,
      ST_RUN,
      ST_BURST,
      ST_FAULT_AUTO,
      ST_FAULT_LATCH
   } mode_e;
endpackage

// ==== rtl/sync2.sv ====
// Two-flop synchroniser for a bank of comparator flags.
`timescale 1ns/1ps
module sync2 #(
   parameter int unsigned W = 1
) (
   input  wire logic         i_clock,
   input  wire logic         i_rstn,
   input  wire logic [W-1:0] i_async,
   output logic      [W-1:0] o_sync
);
   logic [W-1:0] meta_r;
   logic [W-1:0] meta_nxt;
   logic [W-1:0] sync_r;
   logic [W-1:0] sync_nxt;

   always_comb begin
      meta_nxt = i_async;
      sync_nxt = meta_r;
   end

   always_ff @(posedge i_clock) begin
      if (!i_rstn) begin
         meta_r <= '0;
         sync_r <= '0;
      end else begin
         meta_r <= meta_nxt;
         sync_r <= sync_nxt;
      end
   end

   assign o_sync = sync_r;
endmodule

// ==== rtl/fault_filter.sv ====
// Consecutive-cycle fault filter with a sticky fault flag.
`timescale 1ns/1ps
module fault_filter
   import prot_pkg::*;
#(
   parameter int unsigned COUNT = FAULT_CYCLES
) (
   input  wire logic i_clock,
   input  wire logic i_rstn,
   input  wire logic i_strobe,
   input  wire logic i_event,
   input  wire logic i_clear,
   output logic      o_fault
);
   initial begin
      if (COUNT < 1 || COUNT > 255) $error("fault_filter COUNT out of range");
   end

   logic [7:0] cnt_r;
   logic [7:0] cnt_nxt;
   logic       fault_r;
   logic       fault_nxt;

   always_comb begin
      cnt_nxt   = cnt_r;
      fault_nxt = fault_r;
      if (i_clear) begin
         cnt_nxt   = 8'h00;
         fault_nxt = 1'b0;
      end
      if (i_strobe) begin
         if (!i_event) begin
            cnt_nxt = 8'h00;
         end else if (cnt_r < 8'(COUNT)) begin
            cnt_nxt = cnt_r + 8'h01;
         end
         // A qualifying cycle sets the fault even while a clear is present.
         if (i_event && (cnt_r + 8'h01 >= 8'(COUNT))) begin
            fault_nxt = 1'b1;
         end
      end
   end

   always_ff @(posedge i_clock) begin
      if (!i_rstn) begin
         cnt_r   <= 8'h00;
         fault_r <= 1'b0;
      end else begin
         cnt_r   <= cnt_nxt;
         fault_r <= fault_nxt;
      end
   end

   assign o_fault = fault_r;
endmodule

// ==== rtl/flyback_protection_mode_logic.sv ====
// Mode, lockout, jitter and protection control of the flyback controller.
`timescale 1ns/1ps
module flyback_protection_mode_logic
   import prot_pkg::*;
#(
   parameter int unsigned LW           = LEVEL_W,
   parameter int unsigned BLANK_CYC    = UV_BLANK_CYC,
   parameter int unsigned HALF_CYC     = JITTER_HALF_CYC,
   parameter int unsigned DEPTH_PCT    = JITTER_PCT,
   parameter int unsigned HV_PULSE_CYC = STARTUP_PULSE_CYC
) (
   input  wire logic          i_clock,
   input  wire logic          i_rstn,
   input  wire logic          i_latched_variant,
   input  wire logic          i_osc_cycle,
   input  wire logic          i_pwm_on,
   input  wire logic          i_fb_below_burst_entry,
   input  wire logic          i_fb_below_burst_deep,
   input  wire logic          i_fb_above_burst_exit,
   input  wire logic          i_demag_over_ovp,
   input  wire logic          i_demag_under_uvp,
   input  wire logic          i_supply_lockout,
   input  wire logic          i_supply_at_turn_on,
   input  wire logic          i_supply_below_turn_off,
   input  wire logic          i_supply_below_restart,
   input  wire logic          i_mains_present,
   input  wire logic [LW-1:0] i_fb_peak_level,
   input  wire logic [LW-1:0] i_cc_level,
   input  wire logic [LW-1:0] i_burst_clamp_level,
   output logic               o_gate,
   output logic               o_lowered_lockout,
   output logic               o_burst_mode,
   output logic               o_hv_startup_en,
   output logic               o_jitter,
   output logic [LW-1:0]      o_current_limit,
   output logic               o_ov_fault,
   output logic               o_uv_fault
);
   initial begin
      if (LW < 4 || LW > 24) $error("LW out of range");
      if (HALF_CYC < 1 || DEPTH_PCT > 50 || HV_PULSE_CYC < 1)
         $error("timing parameter out of range");
      if (BLANK_CYC < 1) $error("BLANK_CYC out of range");
   end

   ////////////////////////////////////////////////////////////////////////
   // Synchronised comparator flags.
   localparam int unsigned NS = 12;
   logic [NS-1:0] async_in;
   logic [NS-1:0] s;
   logic fb_entry_low;
   logic fb_deep_low;
   logic fb_exit_high;
   logic ov_ev;
   logic uv_ev;
   logic lockout;
   logic at_on;
   logic below_off;
   logic below_rst;
   logic mains;
   logic osc_s;
   logic pwm_s;

   assign async_in = {i_osc_cycle, i_pwm_on, i_fb_below_burst_entry,
                      i_fb_below_burst_deep, i_fb_above_burst_exit,
                      i_demag_over_ovp, i_demag_under_uvp,
                      i_supply_lockout, i_supply_at_turn_on,
                      i_supply_below_turn_off, i_supply_below_restart,
                      i_mains_present};

   sync2 #(.W(NS)) u_sync (
      .i_clock (i_clock),
      .i_rstn  (i_rstn),
      .i_async (async_in),
      .o_sync  (s)
   );

   assign {osc_s, pwm_s, fb_entry_low, fb_deep_low, fb_exit_high, ov_ev,
           uv_ev, lockout, at_on, below_off, below_rst, mains} = s;

   ////////////////////////////////////////////////////////////////////////
   // Oscillator strobe and variant capture.
   logic osc_d_r;
   logic osc_d_nxt;
   logic strobe;
   logic latched_r;
   logic latched_nxt;
   logic cap_done_r;
   logic cap_done_nxt;

   assign strobe = osc_s && !osc_d_r;

   always_comb begin
      osc_d_nxt    = osc_s;
      latched_nxt  = latched_r;
      cap_done_nxt = 1'b1;
      if (!cap_done_r) begin
         latched_nxt = i_latched_variant;
      end
   end

   always_ff @(posedge i_clock) begin
      if (!i_rstn) begin
         osc_d_r    <= 1'b0;
         latched_r  <= 1'b0;
         cap_done_r <= 1'b0;
      end else begin
         osc_d_r    <= osc_d_nxt;
         latched_r  <= latched_nxt;
         cap_done_r <= cap_done_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Fault filters.
   logic ov_fault;
   logic uv_fault;
   logic fault_clear;
   logic uv_blank;

   fault_filter #(.COUNT(FAULT_CYCLES)) u_ov (
      .i_clock  (i_clock),
      .i_rstn   (i_rstn),
      .i_strobe (strobe),
      .i_event  (ov_ev),
      .i_clear  (fault_clear),
      .o_fault  (ov_fault)
   );

   fault_filter #(.COUNT(FAULT_CYCLES)) u_uv (
      .i_clock  (i_clock),
      .i_rstn   (i_rstn),
      .i_strobe (strobe),
      .i_event  (uv_ev && !uv_blank),
      .i_clear  (fault_clear),
      .o_fault  (uv_fault)
   );

   ////////////////////////////////////////////////////////////////////////
   // Operating mode.
   mode_e mode_r;
   mode_e mode_nxt;
   logic  low_lock_r;
   logic  low_lock_nxt;
   logic  armed_r;
   logic  armed_nxt;
   logic  run_start;

   always_comb begin
      mode_nxt     = mode_r;
      low_lock_nxt = low_lock_r;
      armed_nxt    = armed_r;
      fault_clear  = 1'b0;
      run_start    = 1'b0;
      if (fb_deep_low) begin
         low_lock_nxt = 1'b1;
      end else if (fb_exit_high) begin
         low_lock_nxt = 1'b0;
      end
      case (mode_r)
         ST_CHARGE: begin
            if (at_on) begin
               mode_nxt  = ST_RUN;
               run_start = 1'b1;
            end
         end
         ST_RUN, ST_BURST: begin
            if (ov_fault) begin
               mode_nxt  = latched_r ? ST_FAULT_LATCH : ST_FAULT_AUTO;
               armed_nxt = 1'b0;
            end else if (uv_fault) begin
               mode_nxt  = ST_FAULT_AUTO;
               armed_nxt = 1'b0;
            end else if (below_off) begin
               mode_nxt = ST_CHARGE;
            end else if (mode_r == ST_RUN && strobe && fb_deep_low) begin
               mode_nxt = ST_BURST;
            end else if (mode_r == ST_BURST && !fb_entry_low) begin
               mode_nxt = ST_RUN;
            end
         end
         ST_FAULT_AUTO: begin
            if (below_rst) begin
               armed_nxt = 1'b1;
            end
            if (armed_r && at_on) begin
               mode_nxt    = ST_RUN;
               fault_clear = 1'b1;
               run_start   = 1'b1;
            end
         end
         ST_FAULT_LATCH: begin
            if (!mains && below_rst) begin
               mode_nxt    = ST_CHARGE;
               fault_clear = 1'b1;
            end
         end
         default: begin
            mode_nxt = ST_CHARGE;
         end
      endcase
   end

   always_ff @(posedge i_clock) begin
      if (!i_rstn) begin
         mode_r     <= ST_CHARGE;
         low_lock_r <= 1'b0;
         armed_r    <= 1'b0;
      end else begin
         mode_r     <= mode_nxt;
         low_lock_r <= low_lock_nxt;
         armed_r    <= armed_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Undervoltage blanking, jitter and start-up pulse timers.
   // The blanking count is wide enough for the full 20 ms at 200 MHz.
   logic [31:0]  blank_r;
   logic [31:0]  blank_nxt;
   logic [31:0]  jit_cnt_r;
   logic [31:0]  jit_cnt_nxt;
   logic         jit_r;
   logic         jit_nxt;
   logic [31:0]  hv_cnt_r;
   logic [31:0]  hv_cnt_nxt;

   assign uv_blank = (blank_r != 32'h0);

   always_comb begin
      blank_nxt   = blank_r;
      jit_cnt_nxt = jit_cnt_r + 32'h1;
      jit_nxt     = jit_r;
      hv_cnt_nxt  = 32'h0;
      if (run_start) begin
         blank_nxt = 32'(BLANK_CYC);
      end else if (uv_blank) begin
         blank_nxt = blank_r - 32'h1;
      end
      if (jit_cnt_r >= 32'(HALF_CYC - 1)) begin
         jit_cnt_nxt = 32'h0;
         jit_nxt     = !jit_r;
      end
      if (mode_r == ST_FAULT_LATCH && below_off) begin
         hv_cnt_nxt = 32'(HV_PULSE_CYC);
      end else if (mode_r == ST_FAULT_LATCH && hv_cnt_r != 32'h0 &&
                   (hv_cnt_r != 32'h1 || !at_on)) begin
         // Run at least the minimum pulse, then hold until turn-on level.
         hv_cnt_nxt = (hv_cnt_r == 32'h1) ? hv_cnt_r : hv_cnt_r - 32'h1;
      end
   end

   always_ff @(posedge i_clock) begin
      if (!i_rstn) begin
         blank_r   <= 32'h0;
         jit_cnt_r <= 32'h0;
         jit_r     <= 1'b0;
         hv_cnt_r  <= 32'h0;
      end else begin
         blank_r   <= blank_nxt;
         jit_cnt_r <= jit_cnt_nxt;
         jit_r     <= jit_nxt;
         hv_cnt_r  <= hv_cnt_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Current limit and registered outputs.
   logic [LW-1:0] base_lim;
   logic [LW-1:0] jit_step;
   logic [LW-1:0] lim_nxt;
   logic [LW+7:0] prod;
   logic          gate_nxt;
   logic          hv_nxt;

   always_comb begin
      // Burst mode ends above the entry level; the clamp holds until feedback passes the exit level.
      if (mode_r == ST_BURST || low_lock_r) begin
         base_lim = i_burst_clamp_level;
      end else if (i_cc_level < i_fb_peak_level) begin
         base_lim = i_cc_level;
      end else begin
         base_lim = i_fb_peak_level;
      end
      prod     = {8'h00, base_lim} * (LW + 8)'(DEPTH_PCT);
      jit_step = LW'(prod / (LW + 8)'(100));
      lim_nxt  = jit_r ? base_lim - jit_step : base_lim;
      // The gate follows the PWM request only in normal running mode.
      gate_nxt = (mode_r == ST_RUN) && pwm_s && !below_off &&
                 !lockout;
      hv_nxt = (mode_r == ST_CHARGE) || (mode_r == ST_FAULT_AUTO) ||
               (hv_cnt_r != 32'h0);
   end

   always_ff @(posedge i_clock) begin
      if (!i_rstn) begin
         o_gate            <= 1'b0;
         o_lowered_lockout <= 1'b0;
         o_burst_mode      <= 1'b0;
         o_hv_startup_en   <= 1'b1;
         o_jitter          <= 1'b0;
         o_current_limit   <= '0;
         o_ov_fault        <= 1'b0;
         o_uv_fault        <= 1'b0;
      end else begin
         o_gate            <= gate_nxt;
         o_lowered_lockout <= low_lock_r;
         o_burst_mode      <= (mode_r == ST_BURST);
         o_hv_startup_en   <= hv_nxt;
         o_jitter          <= jit_r;
         o_current_limit   <= lim_nxt;
         o_ov_fault        <= ov_fault;
         o_uv_fault        <= uv_fault;
      end
   end
endmodule

// ==== test/flyback_monitor.sv ====
// Concurrent checks on the ports of the flyback mode logic.
`timescale 1ns/1ps
module flyback_monitor
   import prot_pkg::*;
#(
   parameter int unsigned LW       = LEVEL_W,
   parameter int unsigned HALF_CYC = JITTER_HALF_CYC
) (
   input wire logic          i_clock,
   input wire logic          i_rstn,
   input wire logic          i_supply_lockout,
   input wire logic          i_fb_above_burst_exit,
   input wire logic          i_demag_over_ovp,
   input wire logic [LW-1:0] i_fb_peak_level,
   input wire logic [LW-1:0] i_cc_level,
   input wire logic          o_gate,
   input wire logic          o_lowered_lockout,
   input wire logic          o_burst_mode,
   input wire logic          o_hv_startup_en,
   input wire logic          o_jitter,
   input wire logic [LW-1:0] o_current_limit,
   input wire logic          o_ov_fault,
   input wire logic          o_uv_fault
);
   logic          jit_r;
   logic          seen_r;
   logic [31:0]   cnt_r;
   logic [LW-1:0] lo;
   assign lo = (i_cc_level < i_fb_peak_level) ? i_cc_level : i_fb_peak_level;
   default clocking cb @(posedge i_clock); endclocking
   default disable iff (!i_rstn);
   ////////////////////////////////////////////////////////////////////////
   // A phase is too long for a repetition, so it is counted here.
   always_ff @(posedge i_clock) begin
      jit_r <= o_jitter;
      if (!i_rstn) begin
         seen_r <= 1'b0;
         cnt_r  <= 32'h0;
      end else if (o_jitter != jit_r) begin
         seen_r <= 1'b1;
         cnt_r  <= 32'h0;
      end else begin
         cnt_r <= cnt_r + 32'h1;
      end
   end
   ////////////////////////////////////////////////////////////////////////
   sequence s_lock_held; i_supply_lockout [*6]; endsequence
   sequence s_ov_quiet; !i_demag_over_ovp [*8]; endsequence
   sequence s_exit_held;
      i_fb_above_burst_exit [*8] ##1 i_fb_above_burst_exit [*8]
         ##1 i_fb_above_burst_exit [*8];
   endsequence
   sequence s_lv_steady;
      ($stable(i_cc_level) && $stable(i_fb_peak_level)) [*3];
   endsequence
   property p_lock_gate; s_lock_held |-> !o_gate; endproperty
   property p_ov_stop; o_ov_fault [*2] |-> !o_gate; endproperty
   property p_uv_stop; o_uv_fault [*2] |-> !o_gate; endproperty
   property p_burst_off; o_burst_mode [*2] |-> !o_gate; endproperty
   property p_hv_run; o_gate |-> !o_hv_startup_en; endproperty
   property p_jitter;
      (o_jitter != jit_r) && seen_r |-> cnt_r == HALF_CYC - 1;
   endproperty
   property p_ov_quiet; s_ov_quiet |=> !$rose(o_ov_fault); endproperty
   property p_exit; s_exit_held |-> !o_lowered_lockout; endproperty
   property p_limit; s_lv_steady |-> o_current_limit <= lo; endproperty
   a_lock_gate: assert property (p_lock_gate)
      else $error("gate on under lockout");
   a_ov_stop: assert property (p_ov_stop)
      else $error("gate on with overvoltage fault");
   a_uv_stop: assert property (p_uv_stop)
      else $error("gate on with undervoltage fault");
   a_burst_off: assert property (p_burst_off)
      else $error("gate on in burst halt");
   a_hv_run: assert property (p_hv_run)
      else $error("start-up generator on while switching");
   a_jitter: assert property (p_jitter)
      else $error("jitter half period wrong");
   a_ov_quiet: assert property (p_ov_quiet)
      else $error("overvoltage fault without events");
   a_exit: assert property (p_exit)
      else $error("lowered lockout kept above exit level");
   a_limit: assert property (p_limit)
      else $error("current limit above lower level");
endmodule

// ==== test/flyback_partner.sv ====
// Oscillator strobe and held demag comparator flags around the logic.
`timescale 1ns/1ps
module flyback_partner #(
   parameter int unsigned PER = 16
) (
   input  wire logic i_clock,
   input  wire logic i_ov,
   input  wire logic i_uv,
   output logic      o_osc,
   output logic      o_over,
   output logic      o_under
);
   int unsigned cnt = 0;
   initial begin
      o_osc = 1'b0;
      o_over = 1'b0;
      o_under = 1'b0;
   end
   // Flags are taken at the cycle start and held all cycle long.
   always @(posedge i_clock) begin
      cnt = (cnt + 1) % PER;
      o_osc <= (cnt < PER / 2);
      if (cnt == 0) begin
         o_over <= i_ov;
         o_under <= i_uv;
      end
   end
endmodule

// ==== test/tb.sv ====
// Self-checking bench for the flyback mode and protection logic.
`timescale 1ns/1ps
module tb;
   import prot_pkg::*;
   localparam int unsigned LW       = LEVEL_W;
   localparam int unsigned HALF_CYC = 10;
   localparam int unsigned PER      = 16;
   logic          i_clock, i_rstn, latched, pwm, entry, deep, above, lock;
   logic          ton, toff, rst_lo, mains, ov_req, uv_req, chk;
   logic          osc, over, under, gate, lowl, burst, hv, jit, ovf, uvf;
   logic [LW-1:0] fb, cc, clamp, lim;
   logic [6:0]    outv;
   logic [37:0]   exp_q[$];
   int            num_errors = 0;
   int            total_checks = 0;
   assign outv = {gate, lowl, burst, hv, ovf, uvf, jit};
   flyback_protection_mode_logic #(.BLANK_CYC(100), .HALF_CYC(HALF_CYC),
      .HV_PULSE_CYC(20)) i_flyback_protection_mode_logic (.i_clock,
      .i_rstn, .i_latched_variant(latched), .i_osc_cycle(osc),
      .i_pwm_on(pwm), .i_fb_below_burst_entry(entry),
      .i_fb_below_burst_deep(deep), .i_fb_above_burst_exit(above),
      .i_demag_over_ovp(over), .i_demag_under_uvp(under),
      .i_supply_lockout(lock), .i_supply_at_turn_on(ton),
      .i_supply_below_turn_off(toff), .i_supply_below_restart(rst_lo),
      .i_mains_present(mains), .i_fb_peak_level(fb), .i_cc_level(cc),
      .i_burst_clamp_level(clamp), .o_gate(gate), .o_lowered_lockout(lowl),
      .o_burst_mode(burst), .o_hv_startup_en(hv), .o_jitter(jit),
      .o_current_limit(lim), .o_ov_fault(ovf), .o_uv_fault(uvf));
   flyback_partner #(.PER(PER)) i_flyback_partner (.i_clock, .i_ov(ov_req),
      .i_uv(uv_req), .o_osc(osc), .o_over(over), .o_under(under));
   initial begin
      i_clock = 1'b0;
      forever #2.5 i_clock = ~i_clock;
   end
   ////////////////////////////////////////////////////////////////////////
   function automatic bit good(logic [37:0] e);
      return ((outv & e[37:31]) === e[30:24]) && ((lim >= e[23:12]) === 1'b1)
         && ((lim <= e[11:0]) === 1'b1);
   endfunction
   task automatic conclude();
      if (num_errors == 0 && total_checks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   always @(posedge chk) begin : watch
      logic [37:0] e;
      e = exp_q.pop_front();
      total_checks++;
      if (!good(e)) begin
         num_errors++;
         $display("MISMATCH t=%0t exp=%h got=%h", $time, e, {outv, lim});
      end
   end
   // The wait is bounded; running out is reported and ends the run.
   task automatic check_out(input logic [6:0] m, v, input logic [11:0] l, h);
      logic [37:0] e;
      int          n;
      e = {m, v, l, h};
      n = 0;
      while (!good(e) && n < 200) begin
         @(negedge i_clock);
         n++;
      end
      if (!good(e)) begin
         num_errors++;
         $display("MISMATCH t=%0t exp=%h got=%h", $time, e, {outv, lim});
         conclude();
      end else begin
         exp_q.push_back(e);
         chk = 1'b1;
         @(negedge i_clock);
         chk = 1'b0;
         @(negedge i_clock);
      end
   endtask
   task automatic st(input logic [6:0] m, v);
      check_out(m, v, 12'h000, 12'hfff);
   endtask
   task automatic strobes(input logic ov, uv, input int n);
      ov_req = ov;
      uv_req = uv;
      repeat (n * PER) @(negedge i_clock);
   endtask
   task automatic do_reset(input logic v);
      i_rstn = 1'b0;
      latched = v;
      repeat (11) @(negedge i_clock);
      check_out(7'h7e, 7'h08, 12'h000, 12'h000);
      i_rstn = 1'b1;
   endtask
   ////////////////////////////////////////////////////////////////////////
   initial begin
      logic [LW-1:0] lo, d;
      {pwm, entry, deep, lock, ton, toff, rst_lo, ov_req, uv_req, chk} = '0;
      {above, mains, fb, cc} = {2'b11, 12'h800, 12'h900};
      i_rstn = 1'b0;
      latched = 1'b0;
      void'($urandom(32'hf7e77408));
      clamp = 12'($urandom_range(12'h8f, 12'h10));
      do_reset(1'b0);
      pwm = 1'b1;
      ton = 1'b1;
      st(7'h48, 7'h40);
      ton = 1'b0;
      strobes(1'b0, 1'b1, 4);
      st(7'h02, 7'h00);
      strobes(1'b0, 1'b0, 1);
      lock = 1'b1;
      st(7'h40, 7'h00);
      lock = 1'b0;
      st(7'h40, 7'h40);
      {entry, deep, above} = 3'b110;
      strobes(1'b0, 1'b0, 1);
      check_out(7'h70, 7'h30, clamp - 12'h008, clamp);
      deep = 1'b0;
      strobes(1'b0, 1'b0, 1);
      st(7'h30, 7'h30);
      entry = 1'b0;
      strobes(1'b0, 1'b0, 1);
      check_out(7'h70, 7'h60, clamp - 12'h008, clamp);
      above = 1'b1;
      st(7'h20, 7'h00);
      for (int k = 0; k < 4; k++) begin
         fb = 12'($urandom_range(12'hfff, 12'h100));
         cc = 12'($urandom_range(12'hfff, 12'h100));
         lo = (fb < cc) ? fb : cc;
         d = 12'((32'(lo) * JITTER_PCT) / 100);
         check_out(7'h01, 7'h01, lo - d - 12'h1, lo - d + 12'h1);
         check_out(7'h01, 7'h00, lo, lo);
      end
      latched = 1'b1;
      strobes(1'b1, 1'b0, 3);
      strobes(1'b0, 1'b0, 1);
      strobes(1'b1, 1'b0, 3);
      st(7'h04, 7'h00);
      strobes(1'b1, 1'b0, 1);
      ov_req = 1'b0;
      st(7'h44, 7'h04);
      ton = 1'b1;
      repeat (20) @(negedge i_clock);
      st(7'h44, 7'h04);
      ton = 1'b0;
      rst_lo = 1'b1;
      repeat (8) @(negedge i_clock);
      rst_lo = 1'b0;
      ton = 1'b1;
      st(7'h44, 7'h40);
      ton = 1'b0;
      strobes(1'b0, 1'b1, 4);
      st(7'h02, 7'h00);
      strobes(1'b0, 1'b1, 8);
      uv_req = 1'b0;
      st(7'h42, 7'h02);
      do_reset(1'b1);
      ton = 1'b1;
      st(7'h40, 7'h40);
      ton = 1'b0;
      strobes(1'b1, 1'b0, 4);
      ov_req = 1'b0;
      st(7'h44, 7'h04);
      {toff, rst_lo} = 2'b11;
      st(7'h0c, 7'h0c);
      {toff, rst_lo, ton} = 3'b001;
      repeat (20) @(negedge i_clock);
      st(7'h4c, 7'h04);
      {ton, mains, rst_lo} = 3'b001;
      st(7'h04, 7'h00);
      conclude();
   end
endmodule
bind flyback_protection_mode_logic flyback_monitor #(.LW(LW),
   .HALF_CYC(HALF_CYC)) i_flyback_monitor (.i_clock, .i_rstn,
   .i_supply_lockout, .i_fb_above_burst_exit, .i_demag_over_ovp,
   .i_fb_peak_level, .i_cc_level, .o_gate, .o_lowered_lockout,
   .o_burst_mode, .o_hv_startup_en, .o_jitter, .o_current_limit,
   .o_ov_fault, .o_uv_fault);
